// ==== verilog/safety_link_pkg.sv ====
// constants, register map and codes for the safety link status block
package safety_link_pkg;
   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFF_APP_SIZE = 8'h00;
   localparam logic [7:0] OFF_COMM_SIZE = 8'h04;
   localparam logic [7:0] OFF_LINK_ID = 8'h08;
   localparam logic [7:0] OFF_LINK_ROLE = 8'h0C;
   localparam logic [7:0] OFF_LAST_FAULT = 8'h10;
   localparam logic [7:0] OFF_PROTO_REV = 8'h14;
   localparam logic [7:0] OFF_SAFE_ADDR = 8'h18;
   localparam logic [7:0] OFF_CHECKSUM = 8'h1C;
   localparam logic [7:0] OFF_CMD_WORD = 8'h20;
   localparam logic [7:0] OFF_CONTROL = 8'h24;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h28;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
   localparam logic [7:0] OFF_TIMEOUT = 8'h30;
   localparam logic [31:0] UNMAPPED_VALUE = 32'h0000_0000;
   // fixed values
   localparam logic [15:0] APP_SIZE_LOCAL = 16'h0000;
   localparam logic [15:0] APP_SIZE_LINK = 16'h0004;
   localparam logic [15:0] COMM_SIZE_BYTES = 16'h0002;
   localparam logic [15:0] ROLE_SLAVE = 16'h0002;
   localparam logic [15:0] LINK_ID_NONE = 16'h0000;
   localparam logic [15:0] TIMEOUT_DEFAULT_MS = 16'h0064;
   localparam logic [15:0] TIMEOUT_MIN_MS = 16'h0007;
   localparam logic [6:0] ADDR_SCALE = 7'h64;
   // control register bit
   localparam int CTRL_APP_LINK_BIT = 0;
   // interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_TIMEOUT_BIT = 1;
   localparam int IRQ_CMD_BIT = 2;
   // timing: one millisecond in cycles at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int MS_NS = 1000000;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
   localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
   // command words sent by the master
   localparam logic [7:0] CMD_PROCESS = 8'h36;
   localparam logic [7:0] CMD_RESET = 8'h2A;
   localparam logic [7:0] CMD_SESSION = 8'h4E;
   localparam logic [7:0] CMD_CONNECTION = 8'h64;
   localparam logic [7:0] CMD_PARAMETER = 8'h52;
   localparam logic [7:0] CMD_FAILSAFE = 8'h08;
   // last fault codes
   localparam logic [7:0] FLT_RESET = 8'h00;
   localparam logic [7:0] FLT_UNEXPECTED = 8'h01;
   localparam logic [7:0] FLT_UNKNOWN = 8'h02;
   localparam logic [7:0] FLT_BAD_ID = 8'h03;
   localparam logic [7:0] FLT_CRC = 8'h04;
   localparam logic [7:0] FLT_WATCHDOG = 8'h05;
   localparam logic [7:0] FLT_BAD_ADDR = 8'h06;
   localparam logic [7:0] FLT_BAD_DATA = 8'h07;
   localparam logic [7:0] FLT_COMM_LEN = 8'h08;
   localparam logic [7:0] FLT_COMM_DATA = 8'h09;
   localparam logic [7:0] FLT_APP_LEN = 8'h0A;
   localparam logic [7:0] FLT_APP_DATA = 8'h0B;
   localparam logic [7:0] FLT_NONE = 8'hFF;
   // decoded link phase
   typedef enum logic [2:0] {
      PH_RESET, PH_SESSION, PH_CONNECTION, PH_PARAMETER,
      PH_CYCLIC, PH_FALLBACK, PH_UNKNOWN
   } phase_type;
endpackage

// ==== verilog/safety_link_slave_status.sv ====
// status and diagnostic view of one safety link slave connection
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps

// Summary of operation
// R1 - app size 0 local, 4 over link
// R2 - communication parameter size fixed at two
// R3 - hold link identifier assigned by master
// R4 - link role constant two, slave
// R5 - fault codes 0 to 5 recorded
// R6 - fault codes 6 to 11 recorded
// R7 - protocol revision exposed read only
// R8 - address is station times 100 plus axis
// R9 - read-only checksum over safety parameters
// R10 - report master command word as state
// R11 - decode 0x36, 0x2A, 0x4E commands
// R12 - decode 0x64, 0x52, 0x08 commands
// R13 - safe state when frames stop past timeout, except in the reset phase
// R14 - timeout stores code 5, fallback until reset
module safety_link_slave_status #(
   parameter int AXIS_NUMBER = 1,
   parameter int CYCLES_MS = safety_link_pkg::CYCLES_PER_MS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire logic [safety_link_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [safety_link_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [safety_link_pkg::DATA_W-1:0] reg_rdata,
   // frames from the safety link core
   input wire logic frame_valid,
   input wire logic [7:0] frame_command,
   input wire logic [15:0] frame_link_id,
   input wire logic link_id_valid,
   input wire logic [15:0] frame_timeout_ms,
   input wire logic timeout_valid,
   // fault reports from the safety link core
   input wire logic fault_valid,
   input wire logic [7:0] fault_code,
   // configuration from the safety processor
   input wire logic [15:0] link_protocol_revision,
   input wire logic [6:0] safety_station_number,
   input wire logic [31:0] safety_param_checksum,
   // status outputs
   output logic safe_state,
   output logic fallback_values_phase,
   output logic cyclic_exchange_phase,
   output logic irq
);
   import safety_link_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic app_link;
      logic [15:0] link_id;
      logic [7:0] last_fault;
      logic [7:0] cmd_word;
      logic [15:0] timeout_ms;
      logic [31:0] cycle_cnt;
      logic [15:0] ms_cnt;
      logic safe;
      logic cyclic;
      phase_type phase;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_mask;
      logic irq;
   } state_type;

   state_type q;
   state_type d;
   logic [IRQ_W-1:0] irq_clear;

   // one write-one-to-clear enable per status bit
   generate
      for (genvar b = 0; b < IRQ_W; b++) begin : g_irq_bit
         assign irq_clear[b] = reg_write &&
            reg_addr == OFF_IRQ_STATUS && reg_wdata[b];
      end
   endgenerate

   // command word to link phase
   function automatic phase_type decode_cmd(input logic [7:0] c);
      phase_type p;
      p = PH_UNKNOWN;
      unique case (c)
         CMD_PROCESS: begin
            p = PH_CYCLIC; // [R11]
         end
         CMD_RESET: begin
            p = PH_RESET; // [R11]
         end
         CMD_SESSION: begin
            p = PH_SESSION; // [R11]
         end
         CMD_CONNECTION: begin
            p = PH_CONNECTION; // [R12]
         end
         CMD_PARAMETER: begin
            p = PH_PARAMETER; // [R12]
         end
         CMD_FAILSAFE: begin
            p = PH_FALLBACK; // [R12]
         end
         default: begin
            p = PH_UNKNOWN;
         end
      endcase
      return p;
   endfunction

   // address formed from station number and axis
   function automatic logic [15:0] safe_addr(input logic [6:0] sid);
      logic [15:0] prod;
      prod = 16'(sid) * 16'(ADDR_SCALE);
      return prod + 16'(AXIS_NUMBER); // [R8]
   endfunction

   // narrow values sit in the low bits of a bus word
   function automatic logic [DATA_W-1:0] widen16(input logic [15:0] x);
      return DATA_W'(x);
   endfunction

   // byte values sit in the low bits of a bus word
   function automatic logic [DATA_W-1:0] widen8(input logic [7:0] x);
      return DATA_W'(x);
   endfunction

   // register write hit at one offset
   function automatic logic write_hit(
      input logic wr,
      input logic [ADDR_W-1:0] a,
      input logic [ADDR_W-1:0] off
   );
      return wr && a == off;
   endfunction

   // master timeout clamped to its least legal value
   function automatic logic [15:0] clamp_timeout(input logic [15:0] t);
      logic [15:0] r;
      r = t;
      if (t < TIMEOUT_MIN_MS) begin
         r = TIMEOUT_MIN_MS; // [R13]
      end
      return r;
   endfunction

   // end of one millisecond of clock cycles
   function automatic logic ms_tick(input logic [31:0] cnt);
      return cnt == 32'(CYCLES_MS - 1);
   endfunction

   // true when one more millisecond reaches the timeout
   function automatic logic ms_limit(
      input logic [15:0] ms,
      input logic [15:0] limit
   );
      logic [15:0] next_ms;
      next_ms = ms + 16'h0001;
      return next_ms >= limit;
   endfunction

   // watchdog runs only on a live, not yet safe link
   function automatic logic wdog_armed(input state_type s);
      return !s.safe && s.phase != PH_RESET;
   endfunction

   // link reset command from the master
   function automatic logic is_reset_cmd(input logic [7:0] c);
      return c == CMD_RESET;
   endfunction

   // a new command word differs from the held one
   function automatic logic cmd_changed(input logic [7:0] c, h);
      return c != h;
   endfunction

   // nonzero identifier carried with the frame
   function automatic logic id_offered(input logic v, input logic [15:0] id);
      return v && id != LINK_ID_NONE;
   endfunction

   // cyclic exchange only while the link is not safe
   function automatic logic cyclic_ok(input phase_type p, input logic safe);
      return p == PH_CYCLIC && !safe;
   endfunction

   // application parameter size for the chosen source
   function automatic logic [15:0] app_size(input logic over_link);
      logic [15:0] r;
      r = APP_SIZE_LOCAL;
      if (over_link) begin
         r = APP_SIZE_LINK; // [R1]
      end
      return r;
   endfunction

   // sticky status: clear first, so a new event wins
   function automatic logic [IRQ_W-1:0] sticky_next(
      input logic [IRQ_W-1:0] cur,
      input logic [IRQ_W-1:0] clr,
      input logic [IRQ_W-1:0] ev
   );
      logic [IRQ_W-1:0] r;
      r = cur & ~clr;
      r = r | ev;
      return r;
   endfunction

   // level interrupt from unmasked sticky bits
   function automatic logic irq_line(
      input logic [IRQ_W-1:0] st,
      input logic [IRQ_W-1:0] mk
   );
      return |(st & mk);
   endfunction

   // register read mux
   function automatic logic [DATA_W-1:0] read_mux(
      input logic [ADDR_W-1:0] a,
      input state_type s,
      input logic [15:0] rev,
      input logic [6:0] sid,
      input logic [31:0] crc
   );
      logic [DATA_W-1:0] v;
      v = UNMAPPED_VALUE;
      unique case (a)
         OFF_APP_SIZE: begin
            v = widen16(app_size(s.app_link)); // [R1]
         end
         OFF_COMM_SIZE: begin
            v = widen16(COMM_SIZE_BYTES); // [R2]
         end
         OFF_LINK_ID: begin
            v = widen16(s.link_id); // [R3]
         end
         OFF_LINK_ROLE: begin
            v = widen16(ROLE_SLAVE); // [R4]
         end
         OFF_LAST_FAULT: begin
            v = widen8(s.last_fault); // [R5]
         end
         OFF_PROTO_REV: begin
            v = widen16(rev); // [R7]
         end
         OFF_SAFE_ADDR: begin
            v = widen16(safe_addr(sid)); // [R8]
         end
         OFF_CHECKSUM: begin
            v = crc; // [R9]
         end
         OFF_CMD_WORD: begin
            v = widen8(s.cmd_word); // [R10]
         end
         OFF_CONTROL: begin
            v = DATA_W'(s.app_link);
         end
         OFF_IRQ_STATUS: begin
            v = DATA_W'(s.irq_status);
         end
         OFF_IRQ_MASK: begin
            v = DATA_W'(s.irq_mask);
         end
         OFF_TIMEOUT: begin
            v = widen16(s.timeout_ms); // [R13]
         end
         default: begin
            v = UNMAPPED_VALUE;
         end
      endcase
      return v;
   endfunction

   // next state
   always_comb begin
      logic [IRQ_W-1:0] ev;
      logic expire;
      logic [15:0] to;
      ev = '0;
      expire = 1'b0;
      to = frame_timeout_ms;
      d = q;
      d.rdata = reg_read ?
         read_mux(reg_addr, q, link_protocol_revision,
            safety_station_number, safety_param_checksum) :
         UNMAPPED_VALUE;
      // software control
      if (write_hit(reg_write, reg_addr, OFF_CONTROL)) begin
         d.app_link = reg_wdata[CTRL_APP_LINK_BIT]; // [R1]
      end
      if (write_hit(reg_write, reg_addr, OFF_IRQ_MASK)) begin
         d.irq_mask = reg_wdata[IRQ_W-1:0];
      end

      // master timeout setting, clamped to its least value
      if (timeout_valid) begin
         d.timeout_ms = clamp_timeout(to); // [R13]
      end

      // watchdog counts milliseconds since the last frame
      if (frame_valid) begin
         d.cycle_cnt = '0;
         d.ms_cnt = '0;
      end else if (wdog_armed(q)) begin
         if (ms_tick(q.cycle_cnt)) begin
            d.cycle_cnt = '0;
            d.ms_cnt = q.ms_cnt + 16'h0001;
            if (ms_limit(q.ms_cnt, q.timeout_ms)) begin
               expire = 1'b1; // [R13]
            end
         end else begin
            d.cycle_cnt = q.cycle_cnt + 32'h00000001;
         end
      end

      // received frame updates command word and phase
      if (frame_valid) begin
         d.cmd_word = frame_command; // [R10]
         d.phase = decode_cmd(frame_command);
         ev[IRQ_CMD_BIT] = cmd_changed(frame_command, q.cmd_word);
         if (is_reset_cmd(frame_command)) begin
            d.safe = 1'b0; // link reset leaves the fallback state [R14]
            d.last_fault = FLT_RESET; // [R5]
            d.link_id = LINK_ID_NONE;
         end
         if (id_offered(link_id_valid, frame_link_id)) begin
            d.link_id = frame_link_id; // [R3]
         end
      end

      // fault reports, codes 0 to 11 from the link core
      if (fault_valid) begin
         d.last_fault = fault_code; // [R5] [R6]
         d.safe = 1'b1;
         ev[IRQ_FAULT_BIT] = 1'b1;
      end

      // watchdog expiry wins over other fault codes
      if (expire) begin
         d.last_fault = FLT_WATCHDOG; // [R14]
         d.safe = 1'b1; // [R13]
         d.phase = PH_FALLBACK; // [R14]
         ev[IRQ_TIMEOUT_BIT] = 1'b1;
      end

      // sticky status, write one clears, set wins
      d.irq_status = sticky_next(q.irq_status, irq_clear, ev);
      d.irq = irq_line(d.irq_status, d.irq_mask);
      // cyclic flag kept in a flop so the output is registered
      d.cyclic = cyclic_ok(d.phase, d.safe); // [R11]
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q.rdata <= UNMAPPED_VALUE;
         q.app_link <= 1'b0;
         q.link_id <= LINK_ID_NONE;
         q.last_fault <= FLT_NONE;
         q.cmd_word <= CMD_RESET;
         q.timeout_ms <= TIMEOUT_DEFAULT_MS;
         q.cycle_cnt <= '0;
         q.ms_cnt <= '0;
         q.safe <= 1'b1;
         q.cyclic <= 1'b0;
         q.phase <= PH_RESET;
         q.irq_status <= '0;
         q.irq_mask <= '0;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // outputs straight from flops
   assign reg_rdata = q.rdata;
   assign safe_state = q.safe;
   assign fallback_values_phase = q.safe;
   assign cyclic_exchange_phase = q.cyclic;
   assign irq = q.irq;
endmodule

// ==== verification/safety_link_master_model.sv ====
// behavioural safety link master that launches frames at the slave
`timescale 1ns/1ps
module safety_link_master_model (
   // clock
   input wire logic clk,
   // requests from the bench
   input wire logic send,
   input wire logic [7:0] cmd,
   input wire logic [15:0] id,
   input wire logic tmo_go,
   input wire logic [15:0] tmo,
   // frame lines toward the slave
   output logic frame_valid,
   output logic [7:0] frame_command,
   output logic [15:0] frame_link_id,
   output logic link_id_valid,
   output logic [15:0] frame_timeout_ms,
   output logic timeout_valid
);
   // quiet lines at time zero
   initial begin
      frame_valid = 1'b0;
      timeout_valid = 1'b0;
      link_id_valid = 1'b0;
      frame_command = 8'h00;
      frame_link_id = 16'h0000;
      frame_timeout_ms = 16'h0000;
   end
   // one frame a request; idle lines flip so stale values never match
   always @(posedge clk) begin
      frame_valid <= send;
      timeout_valid <= tmo_go;
      link_id_valid <= send && id != 16'h0000;
      frame_command <= send ? cmd : ~frame_command;
      frame_link_id <= send ? id : ~frame_link_id;
      frame_timeout_ms <= tmo_go ? tmo : ~frame_timeout_ms;
   end
endmodule

// ==== verification/safety_link_slave_status_sva.sv ====
// assertions on the ports of the safety link status block
`timescale 1ns/1ps
module safety_link_slave_status_sva #(
   parameter int AXIS_NUMBER = 1
) (
   // clock, reset and register port
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [safety_link_pkg::ADDR_W-1:0] reg_addr,
   input wire logic reg_read,
   input wire logic [safety_link_pkg::DATA_W-1:0] reg_rdata,
   // link side
   input wire logic frame_valid,
   input wire logic [7:0] frame_command,
   input wire logic fault_valid,
   input wire logic [6:0] safety_station_number,
   // status
   input wire logic safe_state,
   input wire logic fallback_values_phase,
   input wire logic cyclic_exchange_phase
);
   import safety_link_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   comm_size_a: assert property (
      reg_read && reg_addr == OFF_COMM_SIZE |=> reg_rdata == 32'h0000_0002)
      else $error("comm size wrong");
   role_const_a: assert property (
      reg_read && reg_addr == OFF_LINK_ROLE |=> reg_rdata == 32'h0000_0002)
      else $error("link role wrong");
   safe_addr_a: assert property (
      reg_read && reg_addr == OFF_SAFE_ADDR |=> reg_rdata ==
      32'($past(safety_station_number)) * 32'h64 + 32'(AXIS_NUMBER))
      else $error("safe address wrong");
   fault_safe_a: assert property (fault_valid |=> safe_state)
      else $error("fault without safe state");
   fallback_tie_a: assert property (fallback_values_phase == safe_state)
      else $error("fallback differs from safe state");
   cyclic_safe_a: assert property (cyclic_exchange_phase |-> !safe_state)
      else $error("cyclic while safe");
   cyclic_enter_a: assert property (
      frame_valid && frame_command == CMD_PROCESS && !safe_state &&
      !fault_valid |=> cyclic_exchange_phase) else $error("no cyclic phase");
   reset_exit_a: assert property (
      frame_valid && frame_command == CMD_RESET && !fault_valid
      |=> !safe_state) else $error("reset frame kept safe state");
   safe_hold_a: assert property (
      safe_state && !(frame_valid && frame_command == CMD_RESET)
      |=> safe_state) else $error("safe state left early");
endmodule
bind safety_link_slave_status safety_link_slave_status_sva #(
   .AXIS_NUMBER(AXIS_NUMBER)
) u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .frame_valid(frame_valid),
   .frame_command(frame_command), .fault_valid(fault_valid),
   .safety_station_number(safety_station_number), .safe_state(safe_state),
   .fallback_values_phase(fallback_values_phase),
   .cyclic_exchange_phase(cyclic_exchange_phase));

// ==== verification/safety_link_slave_status_tb.sv ====
// self-checking bench for the safety link status block
`timescale 1ns/1ps
module safety_link_slave_status_tb;
   import safety_link_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0;
   logic [7:0] addr = 8'h00, m_cmd = 8'h00, fault_c = 8'h00;
   logic [31:0] wd = 32'h0, rdata, v;
   logic m_send = 1'b0, m_tgo = 1'b0, fault_v = 1'b0;
   logic [15:0] m_id = 16'h0, m_tmo = 16'h0, fid, ftm;
   logic fv, fidv, ftv, safe, fb, cyc, irq;
   logic [7:0] fc;
   logic [7:0] codes [6] = '{8'h08, 8'h2A, 8'h4E, 8'h64, 8'h52, 8'h36};
   int failures = 0, checked = 0, n;
   safety_link_master_model u_master (.clk(clk), .send(m_send), .cmd(m_cmd),
      .id(m_id), .tmo_go(m_tgo), .tmo(m_tmo), .frame_valid(fv),
      .frame_command(fc), .frame_link_id(fid), .link_id_valid(fidv),
      .frame_timeout_ms(ftm), .timeout_valid(ftv));
   safety_link_slave_status #(.AXIS_NUMBER(1), .CYCLES_MS(10)) u_dut (
      .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
      .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
      .frame_valid(fv), .frame_command(fc), .frame_link_id(fid),
      .link_id_valid(fidv), .frame_timeout_ms(ftm), .timeout_valid(ftv),
      .fault_valid(fault_v), .fault_code(fault_c),
      .link_protocol_revision(16'h0103), .safety_station_number(7'h0A),
      .safety_param_checksum(32'hC0FF_EE11), .safe_state(safe),
      .fallback_values_phase(fb), .cyclic_exchange_phase(cyc), .irq(irq));
   // 250 MHz clock
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e,
                      input string m);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic frame(input logic [7:0] c, input logic [15:0] i);
      @(posedge clk);
      m_send <= 1'b1;
      m_cmd <= c;
      m_id <= i;
      @(posedge clk);
      m_send <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic fault(input logic [7:0] c);
      @(posedge clk);
      fault_v <= 1'b1;
      fault_c <= c;
      @(posedge clk);
      fault_v <= 1'b0;
   endtask
   task automatic t_regs;
      rd(OFF_LAST_FAULT);
      chk(v, 32'h0000_00FF, "fault after reset");
      rd(OFF_CMD_WORD);
      chk(v, 32'h0000_002A, "command after reset");
      rd(OFF_TIMEOUT);
      chk(v, 32'h0000_0064, "timeout after reset");
      rd(OFF_APP_SIZE);
      chk(v, 32'h0, "app size local");
      wr(OFF_CONTROL, 32'h1);
      rd(OFF_APP_SIZE);
      chk(v, 32'h0000_0004, "app size link");
      wr(OFF_LINK_ROLE, 32'h5);
      rd(OFF_LINK_ROLE);
      chk(v, 32'h0000_0002, "role");
      rd(OFF_COMM_SIZE);
      chk(v, 32'h0000_0002, "comm size");
      rd(8'hFC);
      chk(v, 32'h0, "unmapped");
      rd(OFF_PROTO_REV);
      chk(v, 32'h0000_0103, "revision");
      rd(OFF_CHECKSUM);
      chk(v, 32'hC0FF_EE11, "checksum");
      rd(OFF_SAFE_ADDR);
      chk(v, 32'h0000_03E9, "safe address");
      $display("done t_regs");
   endtask
   task automatic t_link;
      @(posedge clk);
      m_tgo <= 1'b1;
      m_tmo <= 16'h0003;
      @(posedge clk);
      m_tgo <= 1'b0;
      rd(OFF_TIMEOUT);
      chk(v, 32'h0000_0007, "timeout clamp");
      foreach (codes[k]) begin
         frame(codes[k], codes[k] == 8'h64 ? 16'h1234 : 16'h0000);
         rd(OFF_CMD_WORD);
         chk(v, {24'h0, codes[k]}, "command word");
      end
      rd(OFF_LINK_ID);
      chk(v, 32'h0000_1234, "link id");
      rd(OFF_LAST_FAULT);
      chk(v, 32'h0, "reset frame code");
      chk({31'h0, cyc}, 32'h1, "cyclic phase");
      $display("done t_link");
   endtask
   task automatic t_wdog;
      n = 0;
      while (safe !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 200) begin
         failures++;
         final_report();
      end
      chk(32'(n >= 40 && n <= 72), 32'h1, "expiry time");
      rd(OFF_LAST_FAULT);
      chk(v, 32'h0000_0005, "expiry code");
      frame(CMD_PROCESS, 16'h0000);
      chk({31'h0, fb}, 32'h1, "fallback kept");
      chk({31'h0, cyc}, 32'h0, "no cyclic while safe");
      frame(CMD_RESET, 16'h0000);
      chk({31'h0, safe}, 32'h0, "reset frame leaves safe");
      rd(OFF_LINK_ID);
      chk(v, 32'h0, "link id cleared by reset");
      $display("done t_wdog");
   endtask
   task automatic t_irq;
      fault(FLT_CRC);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "masked irq");
      wr(OFF_IRQ_MASK, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "irq raised");
      rd(OFF_IRQ_STATUS);
      chk(v, 32'h0000_0007, "irq status");
      wr(OFF_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      for (int c = 0; c < 12; c++) begin
         fault(8'(c));
         rd(OFF_LAST_FAULT);
         chk(v, 32'(c), "fault code");
      end
      $display("done t_irq");
   endtask
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_link();
      t_wdog();
      t_irq();
      final_report();
   end
endmodule
